// [wwd_regs.vh]
// Purpose: Register map, field positions, reset values and timing counts
//          of the window watchdog.
// Assumes: 32-bit AXI4-Lite data, one register per aligned word.
// Notes:   Included by every design file of the watchdog.
`ifndef WWD_REGS_VH
`define WWD_REGS_VH

// =====================================================================
// Register offsets
// =====================================================================
`define WWD_OFS_CTRL 8'h00
`define WWD_OFS_RELOAD 8'h04
`define WWD_OFS_WINDOW 8'h08
`define WWD_OFS_COUNT 8'h0c
`define WWD_OFS_IRQ_STAT 8'h10
`define WWD_OFS_IRQ_MASK 8'h14
`define WWD_OFS_STATUS 8'h18

// =====================================================================
// Fields
// =====================================================================
`define WWD_CTRL_SRC_WU 0
`define WWD_CTRL_DIV_SHORT 1
`define WWD_EV_OVERFLOW 0
`define WWD_EV_WIN_FAULT 1
`define WWD_EV_SERVICE 2
`define WWD_EV_W 3
`define WWD_STATUS_RUN 0

// =====================================================================
// Reset values
// =====================================================================
// Wake-up clock, divide by 256, reload 0xff00: 256 ticks of 512 us
`define WWD_RST_CTRL 2'h3
`define WWD_RST_RELOAD 16'hff00
`define WWD_RST_WINDOW 16'h0000
`define WWD_RST_MASK 3'h0

// =====================================================================
// Timing
// =====================================================================
`define WWD_DIV_LONG 16384
`define WWD_DIV_SHORT 256
`define WWD_CNT_W 16
`define WWD_DEF_INTERVAL_US 130000
`define WWD_WU_FREQ_KHZ 500
// Wake-up ticks in the default interval, 65000
`define WWD_DEF_WU_TICKS (`WWD_DEF_INTERVAL_US * `WWD_WU_FREQ_KHZ / 1000)

`define WWD_RESP_OKAY 2'b00
`define WWD_RESP_SLVERR 2'b10

`endif

// [wwd_prescaler.v]
// Purpose: Divides the selected source ticks by one of two ratios.
// Assumes: i_src_tick is a one-cycle pulse per source clock period.
// Notes:   i_restart clears the phase so a valid service or overflow reload starts a full period.
`timescale 1ns/1ps
`include "wwd_regs.vh"

module wwd_prescaler #(
    parameter integer DIV_LONG = `WWD_DIV_LONG,
    parameter integer DIV_SHORT = `WWD_DIV_SHORT
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_run,
    input wire i_restart,
    input wire i_src_tick,
    input wire i_div_short,
    output reg o_tick
);
    reg [13:0] cnt_q;
    wire [13:0] last;

    assign last = i_div_short ? DIV_SHORT[13:0] - 14'h0001 :
                  DIV_LONG[13:0] - 14'h0001;

    // =================================================================
    // Divider
    // =================================================================
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q <= 14'h0000;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            o_tick <= 1'b0;
            if (i_restart || !i_run) begin
                cnt_q <= 14'h0000;
            end else if (i_src_tick) begin
                // >= so a ratio switch mid-period cannot overrun
                if (cnt_q >= last) begin
                    cnt_q <= 14'h0000;
                    o_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 14'h0001;
                end
            end
        end
    end
endmodule // wwd_prescaler

// [wwd_top.v]
// Purpose: Window watchdog with AXI4-Lite registers and reset request.
// Assumes: All inputs synchronous to I_CLK_SYS; I_WU_CLK is a slow
//          wake-up clock level, sampled here.
// Notes:   Instruction strobes are one-cycle pulses from the core.
// Function
// - Comes up enabled and counting after reset
// - Disable and enable instructions stop and resume
// - Overflow without service raises reset request
// - Service inside forbidden window raises reset request
// - 16-bit counter, selectable source, divide 16384/256
// - Valid service loads the reload value
// - Power-up setup gives 0.13 s at 500 kHz
`timescale 1ns/1ps
`include "wwd_regs.vh"

module wwd_top #(
    parameter integer CNT_W = `WWD_CNT_W,
    parameter integer DIV_LONG = `WWD_DIV_LONG,
    parameter integer DIV_SHORT = `WWD_DIV_SHORT
) (
    input wire I_CLK_SYS,
    input wire I_RSTN,
    input wire I_CE,
    input wire I_WU_CLK,
    input wire I_GUARD_TIMER_OFF_INSTR,
    input wire I_GUARD_TIMER_ON_INSTR,
    input wire I_SERVICE_INSTR,
    input wire [7:0] I_AWADDR,
    input wire I_AWVALID,
    output reg O_AWREADY,
    input wire [31:0] I_WDATA,
    input wire [3:0] I_WSTRB,
    input wire I_WVALID,
    output reg O_WREADY,
    output reg [1:0] O_BRESP,
    output reg O_BVALID,
    input wire I_BREADY,
    input wire [7:0] I_ARADDR,
    input wire I_ARVALID,
    output reg O_ARREADY,
    output reg [31:0] O_RDATA,
    output reg [1:0] O_RRESP,
    output reg O_RVALID,
    input wire I_RREADY,
    output reg O_RST_REQ,
    output reg O_IRQ
);
    // =================================================================
    // Functions
    // =================================================================
    function mapped;
        input [7:0] a;
        begin
            case (a)
                `WWD_OFS_CTRL, `WWD_OFS_RELOAD, `WWD_OFS_WINDOW,
                `WWD_OFS_COUNT, `WWD_OFS_IRQ_STAT, `WWD_OFS_IRQ_MASK,
                `WWD_OFS_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // Byte-lane merge for the 16-bit fields
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // =================================================================
    // Registers
    // =================================================================
    reg [1:0] ctrl_q;
    reg [15:0] reload_q;
    reg [15:0] window_q;
    reg [`WWD_EV_W-1:0] irq_stat_q;
    reg [`WWD_EV_W-1:0] irq_mask_q;
    reg run_q;
    reg [CNT_W-1:0] cnt_q;
    reg wu_q;

    reg aw_got_q;
    reg w_got_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    wire src_tick;
    wire div_tick;
    wire svc;
    wire svc_fault;
    wire svc_ok;
    wire ovf;
    wire wr_fire;
    wire [CNT_W-1:0] reload_w;
    wire [`WWD_EV_W-1:0] ev_set;
    wire [`WWD_EV_W-1:0] ev_clr;
    wire [`WWD_EV_W-1:0] irq_stat_d;

    // =================================================================
    // Clock source selection
    // =================================================================
    // Wake-up clock is slow and level-sampled; its rising edge is a tick
    assign src_tick = ctrl_q[`WWD_CTRL_SRC_WU] ? (I_WU_CLK && !wu_q) :
                      1'b1;

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            wu_q <= 1'b0;
        end else if (I_CE) begin
            wu_q <= I_WU_CLK;
        end
    end

    wwd_prescaler #(
        .DIV_LONG(DIV_LONG),
        .DIV_SHORT(DIV_SHORT)
    ) u_presc (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_run(run_q),
        .i_restart(svc_ok || ovf),
        .i_src_tick(src_tick),
        .i_div_short(ctrl_q[`WWD_CTRL_DIV_SHORT]),
        .o_tick(div_tick)
    );

    // =================================================================
    // Enable control
    // =================================================================
    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            run_q <= 1'b1;
        end else if (I_CE) begin
            // Disable wins if both arrive together: fail towards quiet
            if (I_GUARD_TIMER_OFF_INSTR) begin
                run_q <= 1'b0;
            end else if (I_GUARD_TIMER_ON_INSTR) begin
                run_q <= 1'b1;
            end
        end
    end

    // =================================================================
    // Counter, service and window check
    // =================================================================
    // Service is only meaningful while running; ignored when stopped
    assign svc = I_SERVICE_INSTR && run_q;
    assign svc_fault = svc && (cnt_q < window_q[CNT_W-1:0]);
    assign svc_ok = svc && !svc_fault;
    assign ovf = run_q && div_tick && (&cnt_q);
    assign reload_w = reload_q[CNT_W-1:0];

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            cnt_q <= `WWD_RST_RELOAD;
        end else if (I_CE) begin
            if (svc_ok || ovf || svc_fault) begin
                cnt_q <= reload_w;
            end else if (run_q && div_tick) begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_RST_REQ <= 1'b0;
        end else if (I_CE) begin
            O_RST_REQ <= ovf || svc_fault;
        end
    end

    // =================================================================
    // Interrupt status, set wins over write-one-to-clear
    // =================================================================
    assign ev_set = {svc_ok, svc_fault, ovf};
    assign ev_clr = (wr_fire && awaddr_q == `WWD_OFS_IRQ_STAT &&
                     wstrb_q[0]) ? wdata_q[`WWD_EV_W-1:0] :
                    {`WWD_EV_W{1'b0}};
    assign irq_stat_d = (irq_stat_q & ~ev_clr) | ev_set;

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            irq_stat_q <= {`WWD_EV_W{1'b0}};
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            irq_stat_q <= irq_stat_d;
            O_IRQ <= |(irq_stat_d & irq_mask_q);
        end
    end

    // =================================================================
    // AXI4-Lite write channel
    // =================================================================
    // Address and data are latched independently; response after both
    assign wr_fire = aw_got_q && w_got_q && !O_BVALID;

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= `WWD_RESP_OKAY;
        end else if (I_CE) begin
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            if (I_AWVALID && !aw_got_q && !O_AWREADY) begin
                O_AWREADY <= 1'b1;
            end
            if (I_AWVALID && O_AWREADY) begin
                aw_got_q <= 1'b1;
                awaddr_q <= {I_AWADDR[7:2], 2'b00};
            end
            if (I_WVALID && !w_got_q && !O_WREADY) begin
                O_WREADY <= 1'b1;
            end
            if (I_WVALID && O_WREADY) begin
                w_got_q <= 1'b1;
                wdata_q <= I_WDATA;
                wstrb_q <= I_WSTRB;
            end
            if (wr_fire) begin
                O_BVALID <= 1'b1;
                O_BRESP <= mapped(awaddr_q) ? `WWD_RESP_OKAY :
                           `WWD_RESP_SLVERR;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            ctrl_q <= `WWD_RST_CTRL;
            reload_q <= `WWD_RST_RELOAD;
            window_q <= `WWD_RST_WINDOW;
            irq_mask_q <= `WWD_RST_MASK;
        end else if (I_CE && wr_fire) begin
            case (awaddr_q)
                `WWD_OFS_CTRL: begin
                    if (wstrb_q[0]) begin
                        ctrl_q <= wdata_q[1:0];
                    end
                end
                `WWD_OFS_RELOAD: begin
                    reload_q <= merge16(reload_q, wdata_q, wstrb_q);
                end
                `WWD_OFS_WINDOW: begin
                    window_q <= merge16(window_q, wdata_q, wstrb_q);
                end
                `WWD_OFS_IRQ_MASK: begin
                    if (wstrb_q[0]) begin
                        irq_mask_q <= wdata_q[`WWD_EV_W-1:0];
                    end
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // =================================================================
    // AXI4-Lite read channel
    // =================================================================
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case ({I_ARADDR[7:2], 2'b00})
            `WWD_OFS_CTRL: rd_mux[1:0] = ctrl_q;
            `WWD_OFS_RELOAD: rd_mux[15:0] = reload_q;
            `WWD_OFS_WINDOW: rd_mux[15:0] = window_q;
            `WWD_OFS_COUNT: rd_mux[CNT_W-1:0] = cnt_q;
            `WWD_OFS_IRQ_STAT: rd_mux[`WWD_EV_W-1:0] = irq_stat_q;
            `WWD_OFS_IRQ_MASK: rd_mux[`WWD_EV_W-1:0] = irq_mask_q;
            `WWD_OFS_STATUS: rd_mux[`WWD_STATUS_RUN] = run_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= `WWD_RESP_OKAY;
        end else if (I_CE) begin
            O_ARREADY <= 1'b0;
            if (I_ARVALID && !O_ARREADY && !O_RVALID) begin
                O_ARREADY <= 1'b1;
            end
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_mux;
                O_RRESP <= mapped({I_ARADDR[7:2], 2'b00}) ?
                           `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
            end
            if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
endmodule // wwd_top

// [wwd_top_sva.sv]
// Purpose: Port-level checks of the window watchdog.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to wwd_top; sees its ports only.
`timescale 1ns/1ps

module wwd_top_sva (
    input wire I_CLK_SYS,
    input wire I_RSTN,
    input wire I_CE,
    input wire I_GUARD_TIMER_OFF_INSTR,
    input wire I_GUARD_TIMER_ON_INSTR,
    input wire I_SERVICE_INSTR,
    input wire I_AWVALID,
    input wire O_AWREADY,
    input wire I_WVALID,
    input wire O_WREADY,
    input wire [1:0] O_BRESP,
    input wire O_BVALID,
    input wire I_BREADY,
    input wire I_ARVALID,
    input wire O_ARREADY,
    input wire [31:0] O_RDATA,
    input wire O_RVALID,
    input wire I_RREADY,
    input wire O_RST_REQ,
    input wire O_IRQ
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);
    // ==========
    // Bus handshakes
    a_aw_single: assert property (O_AWREADY |=> !O_AWREADY)
        else $error("write address ready held too long");
    a_wr_resp: assert property (O_AWREADY && I_AWVALID && O_WREADY &&
        I_WVALID |-> ##[1:2] O_BVALID)
        else $error("write response late");
    a_b_hold: assert property (O_BVALID && !I_BREADY |=>
        O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    a_rd_resp: assert property (O_ARREADY && I_ARVALID |=> O_RVALID)
        else $error("read data late");
    a_r_hold: assert property (O_RVALID && !I_RREADY |=>
        O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
    a_r_done: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read data repeated");
    // ==========
    // Watchdog behaviour
    a_rst_quiet: assert property ($rose(I_RSTN) |->
        !O_IRQ && !O_RST_REQ && !O_BVALID && !O_RVALID)
        else $error("outputs active after reset");
    a_off_quiet: assert property (
        I_GUARD_TIMER_OFF_INSTR && I_CE && !I_GUARD_TIMER_ON_INSTR ##1
        !I_GUARD_TIMER_ON_INSTR [*6] |-> !O_RST_REQ)
        else $error("reset request while stopped");
    a_ce_freeze: assert property (!I_CE |=> $stable(O_RST_REQ) &&
        $stable(O_IRQ) && $stable(O_RVALID))
        else $error("outputs moved with clock enable low");
    c_rst: cover property (O_RST_REQ);
    c_irq: cover property (O_IRQ);
    c_srv: cover property (I_SERVICE_INSTR && I_CE);
endmodule // wwd_top_sva

bind wwd_top wwd_top_sva wwd_top_sva_i (
    .I_CLK_SYS(I_CLK_SYS),
    .I_RSTN(I_RSTN),
    .I_CE(I_CE),
    .I_GUARD_TIMER_OFF_INSTR(I_GUARD_TIMER_OFF_INSTR),
    .I_GUARD_TIMER_ON_INSTR(I_GUARD_TIMER_ON_INSTR),
    .I_SERVICE_INSTR(I_SERVICE_INSTR),
    .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY),
    .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY),
    .O_RDATA(O_RDATA),
    .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY),
    .O_RST_REQ(O_RST_REQ),
    .O_IRQ(O_IRQ)
);

// [wwd_top_test.sv]
// Purpose: Self-checking bench for the window watchdog.
// Assumes: Dividers shortened to 4 and 8 to keep the run short.
// Notes:   Wake-up clock is a level with a 4-cycle period.
`timescale 1ns/1ps
`include "wwd_regs.vh"

module wwd_top_test;
    localparam int DS = 4;
    localparam int DL = 8;
    localparam int WUP = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic wu = 1'b0;
    logic [1:0] wuc = 2'h0;
    logic off_i = 1'b0;
    logic on_i = 1'b0;
    logic srv = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, rst_req, irq;
    wire [1:0] bresp;
    wire [1:0] rresp;
    wire [31:0] rdata;
    int n_fail = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        wuc <= wuc + 2'h1;
        wu <= wuc[1];
        if (rst_req === 1'b1) n_rst <= n_rst + 1;
    end

    wwd_top #(.DIV_LONG(DL), .DIV_SHORT(DS)) wwd_top_i (
        .I_CLK_SYS(clk), .I_RSTN(rstn), .I_CE(ce), .I_WU_CLK(wu),
        .I_GUARD_TIMER_OFF_INSTR(off_i), .I_GUARD_TIMER_ON_INSTR(on_i),
        .I_SERVICE_INSTR(srv), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .O_RST_REQ(rst_req), .O_IRQ(irq));

    task automatic end_of_test;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang;
        chk(34'h0, 34'h1);
        end_of_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        int k;
        bit done;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            done = bready && bvalid;
            if (bvalid && !done) bready <= 1'b1;
        end while (!done && k < 40);
        bready <= 1'b0;
        if (!done) hang();
        chk({32'h0, bresp}, {32'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int k;
        bit done;
        k = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
            done = rready && rvalid;
            if (rvalid && !done) rready <= 1'b1;
            if (done) chk({rresp, rdata}, {er, e});
        end while (!done && k < 40);
        rready <= 1'b0;
        if (!done) hang();
    endtask

    // Kind 0 off, 1 on, 2 service; one-cycle strobe
    task automatic pulse(input int w);
        @(posedge clk);
        off_i <= (w == 0);
        on_i <= (w == 1);
        srv <= (w == 2);
        @(posedge clk);
        off_i <= 1'b0;
        on_i <= 1'b0;
        srv <= 1'b0;
    endtask

    task automatic wait_rst(input int lo, input int hi);
        int k;
        k = 0;
        while (rst_req !== 1'b1 && k <= hi) begin
            @(posedge clk);
            k++;
        end
        if (k > hi) hang();
        chk((k < lo) ? k : lo, lo);
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        wait_rst(256*DS*WUP - 24, 256*DS*WUP + 24);
        rd(`WWD_OFS_CTRL, 32'h3, 2'b00);
        rd(`WWD_OFS_RELOAD, 32'hff00, 2'b00);
        rd(`WWD_OFS_WINDOW, 32'h0, 2'b00);
        rd(`WWD_OFS_IRQ_MASK, 32'h0, 2'b00);
        rd(`WWD_OFS_STATUS, 32'h1, 2'b00);
        rd(`WWD_OFS_IRQ_STAT, 32'h1, 2'b00);
        rd(8'h1c, 32'h0, 2'b10);
        wr(8'h1c, 32'h1, 2'b10);
        for (int i = 0; i < 2; i++) begin
            wr(`WWD_OFS_CTRL, i ? 32'h2 : 32'h0, 2'b00);
            wr(`WWD_OFS_RELOAD, 32'hfff0, 2'b00);
            pulse(2);
            wait_rst(16*(i ? DS : DL) - 3, 16*(i ? DS : DL) + 4);
        end
        // Let the count of the last reset request settle first
        @(posedge clk);
        n = n_rst;
        repeat (5) begin
            pulse(2);
            repeat (38) @(posedge clk);
        end
        chk(n_rst, n);
        pulse(2);
        wr(`WWD_OFS_WINDOW, 32'hfff8, 2'b00);
        pulse(2);
        wait_rst(0, 3);
        rd(`WWD_OFS_IRQ_STAT, 32'h7, 2'b00);
        wr(`WWD_OFS_IRQ_STAT, 32'h7, 2'b00);
        rd(`WWD_OFS_IRQ_STAT, 32'h0, 2'b00);
        repeat (32) @(posedge clk);
        n = n_rst;
        pulse(2);
        repeat (4) @(posedge clk);
        chk(n_rst, n);
        rd(`WWD_OFS_IRQ_STAT, 32'h4, 2'b00);
        wr(`WWD_OFS_IRQ_MASK, 32'h4, 2'b00);
        repeat (2) @(posedge clk);
        chk(irq, 34'h1);
        wr(`WWD_OFS_IRQ_MASK, 32'h0, 2'b00);
        repeat (2) @(posedge clk);
        chk(irq, 34'h0);
        wr(`WWD_OFS_IRQ_MASK, 32'h4, 2'b00);
        wr(`WWD_OFS_IRQ_STAT, 32'h4, 2'b00);
        repeat (2) @(posedge clk);
        chk(irq, 34'h0);
        // Stop, then freeze the clock enable while stopped
        pulse(0);
        n = n_rst;
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        repeat (200) @(posedge clk);
        chk(n_rst, n);
        rd(`WWD_OFS_STATUS, 32'h0, 2'b00);
        pulse(2);
        rd(`WWD_OFS_IRQ_STAT, 32'h0, 2'b00);
        pulse(1);
        rd(`WWD_OFS_STATUS, 32'h1, 2'b00);
        wait_rst(1, 80);
        wr(`WWD_OFS_IRQ_MASK, 32'h1, 2'b00);
        repeat (2) @(posedge clk);
        chk(irq, 34'h1);
        end_of_test();
    end
endmodule // wwd_top_test
